// ### common/t1_tx_alarm_pkg.sv
package t1_tx_alarm_pkg;
    // Register offsets on the microprocessor port.
    localparam logic [7:0] ADDR_TX_ALARM_CTRL = 8'h11;
    localparam logic [7:0] ADDR_LINE_DATA_LINK_CTRL = 8'h12;
    localparam logic [7:0] ADDR_TX_BIT_MESSAGE = 8'h13;
    // Reset values; the all-ones control idles high (inactive).
    localparam logic [7:0] RST_TX_ALARM_CTRL = 8'h10;
    localparam logic [7:0] RST_LINE_DATA_LINK_CTRL = 8'h00;
    localparam logic [7:0] RST_TX_BIT_MESSAGE = 8'h00;
    // Transmit alarm control field positions.
    localparam int B_SUPERFRAME_YELLOW_TX = 7;
    localparam int B_SECONDARY_YELLOW_TX = 6;
    localparam int B_CHANNEL_BIT2_YELLOW = 5;
    localparam int B_TX_ALL_ONES_N = 4;
    localparam int B_LOOP_UP_CODE_TX = 3;
    localparam int B_LOOP_DOWN_CODE_TX = 2;
    localparam int B_SECONDARY_ALARM_TRUNK = 1;
    localparam int B_OVERHEAD_OVERRIDE = 0;
    // Data link control field positions.
    localparam int B_EXTERNAL_LINK_ENABLE = 7;
    localparam int B_BIT_MESSAGE_ENABLE = 6;
    localparam int B_FDL_HDLC_SELECT = 5;
    localparam int B_CHANNEL_HDLC_SELECT = 4;
    localparam int B_TX_MULTIFRAME_ALIGN = 3;
    localparam int B_TRANSPARENT_MODE = 2;
    localparam int B_JAPAN_SYNC_MODE = 1;
    localparam int B_CHANNEL_LINK_RATE_SEL = 0;
    // Frame geometry: bit 0 is the S bit, 1..192 carry 24 channels.
    localparam logic [7:0] LAST_BIT_OF_FRAME = 8'hc0;
    localparam logic [7:0] FIRST_BIT_OF_CH24 = 8'hb9;
    localparam logic [4:0] ESF_FRAMES = 5'h18;
    localparam logic [4:0] D4_FRAMES = 5'h0c;
    localparam logic [4:0] SECONDARY_YELLOW_FRAME = 5'h0c;
    localparam logic [2:0] LOOP_UP_LEN = 3'h5;
    localparam logic [1:0] LOOP_DOWN_LEN = 2'h3;
endpackage

// ### rtl/t1_tx_alarm_and_data_link_ctrl.sv
`timescale 1ns/1ps
module t1_tx_alarm_and_data_link_ctrl
(
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic i_cs,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    output logic [7:0] o_rdata,
    output logic o_rdata_valid,
    input wire logic i_esf_mode,
    input wire logic i_bit_en,
    input wire logic i_backplane_data_in,
    output logic o_backplane_data_take,
    input wire logic i_crc6_bit,
    input wire logic i_ext_link_bit,
    output logic o_ext_link_take,
    input wire logic i_hdlc_fdl_bit,
    output logic o_hdlc_fdl_take,
    input wire logic i_hdlc_chan_bit,
    output logic o_hdlc_chan_take,
    output logic o_line_tx_bit,
    output logic o_line_tx_valid,
    output logic o_line_tx_sbit,
    input wire logic i_rx_sbit_strobe,
    input wire logic i_rx_sbit,
    input wire logic [4:0] i_rx_frame_num,
    output logic o_rx_fs_error_count_en,
    output logic o_secondary_yellow_det,
    input wire logic i_secondary_yellow_clr,
    output logic o_rx_link_enable,
    output logic o_crc_include_sbits,
    output logic o_transparent_mode
);
    import t1_tx_alarm_pkg::*;

    typedef struct packed {
        logic [7:0] alarm_r;
        logic [7:0] link_r;
        logic [7:0] msg_r;
        logic [7:0] rdata_r;
        logic rvalid_r;
        logic [7:0] bit_r;
        logic [4:0] frame_r;
        logic [3:0] fdl_r;
        logic [2:0] lu_r;
        logic [1:0] ld_r;
        logic line_bit_r;
        logic line_valid_r;
        logic line_sbit_r;
        logic sec_yel_r;
    } state_t;

    state_t st_r;
    state_t st_nxt;

    // D4 framing pattern for frames 1..12: Ft on odd, Fs on even frames.
    function automatic logic d4_sbit(input logic [4:0] f);
        logic [4:0] i;
        i = 5'((f - 5'h01) >> 1);
        if (f[0])
            d4_sbit = ~i[0];
        else
            d4_sbit = (i == 5'h2) || (i == 5'h3) || (i == 5'h4);
    endfunction

    // ESF framing pattern sequence 001011 in frames 4, 8, ... 24.
    function automatic logic esf_fps(input logic [4:0] f);
        logic [4:0] i;
        i = 5'(f >> 2);
        esf_fps = (i == 5'h3) || (i == 5'h5) || (i == 5'h6);
    endfunction

    logic [7:0] alarm;
    logic [7:0] link;
    logic esf;
    logic [4:0] frames;
    logic sslot;
    logic [2:0] ch_bit;
    logic ch24;
    logic fdl_slot;
    logic fs_slot;
    logic pattern_on;
    logic pattern_bit;
    logic sbit;
    logic data_bit;
    logic next_bit;

    assign alarm = st_r.alarm_r;
    assign link = st_r.link_r;
    assign esf = i_esf_mode;
    assign frames = esf ? ESF_FRAMES : D4_FRAMES;
    assign sslot = (st_r.bit_r == 8'h00);
    assign ch_bit = 3'((st_r.bit_r - 8'h01) & 8'h07);
    assign ch24 = (st_r.bit_r >= FIRST_BIT_OF_CH24);
    assign fdl_slot = esf && sslot && st_r.frame_r[0];
    assign fs_slot = !esf && sslot && !st_r.frame_r[0];
    // The all-ones control wins, then loop-up, then loop-down.
    assign pattern_on = !alarm[B_TX_ALL_ONES_N] || alarm[B_LOOP_UP_CODE_TX]
        || alarm[B_LOOP_DOWN_CODE_TX];

    always_comb
    begin
        if (!alarm[B_TX_ALL_ONES_N])
            pattern_bit = 1'b1;
        else if (alarm[B_LOOP_UP_CODE_TX])
            pattern_bit = (st_r.lu_r == LOOP_UP_LEN - 3'h1);
        else
            pattern_bit = (st_r.ld_r == LOOP_DOWN_LEN - 2'h1);
    end

    // Overhead bit selection for the S-bit slot.
    always_comb
    begin
        o_ext_link_take = 1'b0;
        o_hdlc_fdl_take = 1'b0;
        if (esf)
        begin
            if (!st_r.frame_r[0] && !st_r.frame_r[1])
                sbit = esf_fps(st_r.frame_r);
            else if (!st_r.frame_r[0])
                sbit = i_crc6_bit;
            else if (alarm[B_SUPERFRAME_YELLOW_TX])
                sbit = link[B_JAPAN_SYNC_MODE] || !st_r.fdl_r[3];
            else if (link[B_EXTERNAL_LINK_ENABLE])
            begin
                sbit = i_ext_link_bit;
                o_ext_link_take = i_bit_en && sslot;
            end
            else if (link[B_BIT_MESSAGE_ENABLE])
                sbit = !st_r.fdl_r[3] || st_r.msg_r[3'(~st_r.fdl_r[2:0])];
            else if (link[B_FDL_HDLC_SELECT])
            begin
                sbit = i_hdlc_fdl_bit;
                o_hdlc_fdl_take = i_bit_en && sslot;
            end
            else
                sbit = 1'b1;
        end
        else if (fs_slot && link[B_EXTERNAL_LINK_ENABLE])
        begin
            sbit = i_ext_link_bit;
            o_ext_link_take = i_bit_en;
        end
        else if (fs_slot && alarm[B_SECONDARY_YELLOW_TX]
                 && st_r.frame_r == SECONDARY_YELLOW_FRAME)
            sbit = 1'b1;
        else
            sbit = d4_sbit(st_r.frame_r);
        o_ext_link_take = o_ext_link_take && (fdl_slot || fs_slot);
        o_hdlc_fdl_take = o_hdlc_fdl_take && fdl_slot;
    end

    // Payload bit selection for channel slots.
    always_comb
    begin
        o_backplane_data_take = 1'b0;
        o_hdlc_chan_take = 1'b0;
        if (ch24 && link[B_CHANNEL_HDLC_SELECT])
        begin
            // Bit 8 is held at one at 56 kbit/s, so forced stuffing on an
            // all-zero octet cannot corrupt the link data.
            if (ch_bit == 3'h7 && !link[B_CHANNEL_LINK_RATE_SEL])
                data_bit = 1'b1;
            else
            begin
                data_bit = i_hdlc_chan_bit;
                o_hdlc_chan_take = i_bit_en;
            end
        end
        else
        begin
            data_bit = i_backplane_data_in;
            o_backplane_data_take = i_bit_en;
        end
        if (alarm[B_CHANNEL_BIT2_YELLOW] && ch_bit == 3'h1)
            data_bit = 1'b0;
    end

    always_comb
    begin
        if (pattern_on && (sslot -> !alarm[B_OVERHEAD_OVERRIDE]))
            next_bit = pattern_bit;
        else if (link[B_TRANSPARENT_MODE])
            next_bit = i_backplane_data_in;
        else if (sslot)
            next_bit = sbit;
        else
            next_bit = data_bit;
    end

    always_comb
    begin
        st_nxt = st_r;
        st_nxt.rvalid_r = 1'b0;
        if (i_cs && i_wr)
        begin
            if (i_addr == ADDR_TX_ALARM_CTRL)
                st_nxt.alarm_r = i_wdata;
            else if (i_addr == ADDR_LINE_DATA_LINK_CTRL)
                st_nxt.link_r = i_wdata;
            else if (i_addr == ADDR_TX_BIT_MESSAGE)
                st_nxt.msg_r = i_wdata;
        end
        if (i_cs && i_rd)
        begin
            st_nxt.rvalid_r = 1'b1;
            if (i_addr == ADDR_TX_ALARM_CTRL)
                st_nxt.rdata_r = st_r.alarm_r;
            else if (i_addr == ADDR_LINE_DATA_LINK_CTRL)
                st_nxt.rdata_r = st_r.link_r;
            else if (i_addr == ADDR_TX_BIT_MESSAGE)
                st_nxt.rdata_r = st_r.msg_r;
            else
                st_nxt.rdata_r = 8'h00;
        end
        st_nxt.line_valid_r = i_bit_en;
        if (i_bit_en)
        begin
            st_nxt.line_bit_r = next_bit;
            st_nxt.line_sbit_r = sslot;
            if (pattern_on && !link[B_TRANSPARENT_MODE]
                && (sslot -> !alarm[B_OVERHEAD_OVERRIDE]))
            begin
                st_nxt.lu_r = (st_r.lu_r == LOOP_UP_LEN - 3'h1) ? 3'h0
                    : st_r.lu_r + 3'h1;
                st_nxt.ld_r = (st_r.ld_r == LOOP_DOWN_LEN - 2'h1) ? 2'h0
                    : st_r.ld_r + 2'h1;
            end
            if (fdl_slot)
                st_nxt.fdl_r = st_r.fdl_r + 4'h1;
            if (st_r.bit_r == LAST_BIT_OF_FRAME)
            begin
                st_nxt.bit_r = 8'h00;
                st_nxt.frame_r = (st_r.frame_r >= frames) ? 5'h01
                    : st_r.frame_r + 5'h01;
            end
            else
                st_nxt.bit_r = st_r.bit_r + 8'h01;
        end
        // Realigning restarts the superframe at the next frame-1 S bit
        // the receiver reports; a mid-frame jump is accepted as a one-off
        // glitch on the line rather than delaying alignment.
        if (link[B_TX_MULTIFRAME_ALIGN] && i_rx_sbit_strobe
            && i_rx_frame_num == 5'h01)
        begin
            st_nxt.frame_r = 5'h01;
            st_nxt.bit_r = 8'h01;
        end
        if (i_secondary_yellow_clr)
            st_nxt.sec_yel_r = 1'b0;
        if (i_rx_sbit_strobe && !esf && alarm[B_SECONDARY_ALARM_TRUNK]
            && i_rx_frame_num == SECONDARY_YELLOW_FRAME && i_rx_sbit)
            st_nxt.sec_yel_r = 1'b1;
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (i_reset)
        begin
            st_r <= '0;
            st_r.alarm_r <= RST_TX_ALARM_CTRL;
            st_r.link_r <= RST_LINE_DATA_LINK_CTRL;
            st_r.msg_r <= RST_TX_BIT_MESSAGE;
            st_r.frame_r <= 5'h01;
        end
        else
            st_r <= st_nxt;
    end

    // With the secondary alarm trunk bit set, the frame-12 Fs bit is left out of framing error counting.
    assign o_rx_fs_error_count_en = i_rx_sbit_strobe && !esf
        && !i_rx_frame_num[0]
        && !(alarm[B_SECONDARY_ALARM_TRUNK]
             && i_rx_frame_num == SECONDARY_YELLOW_FRAME);
    assign o_rx_link_enable = 1'b1;
    assign o_crc_include_sbits = link[B_JAPAN_SYNC_MODE];
    assign o_transparent_mode = link[B_TRANSPARENT_MODE];
    assign o_secondary_yellow_det = st_r.sec_yel_r;
    assign o_rdata = st_r.rdata_r;
    assign o_rdata_valid = st_r.rvalid_r;
    assign o_line_tx_bit = st_r.line_bit_r;
    assign o_line_tx_valid = st_r.line_valid_r;
    assign o_line_tx_sbit = st_r.line_sbit_r;
endmodule

// ### tb/t1_tx_alarm_sva.sv
`timescale 1ns/1ps
module t1_tx_alarm_sva
    import t1_tx_alarm_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic i_cs,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic [7:0] o_rdata,
    input wire logic o_rdata_valid,
    input wire logic i_bit_en,
    input wire logic o_line_tx_bit,
    input wire logic o_line_tx_valid,
    input wire logic i_rx_sbit_strobe,
    input wire logic i_rx_sbit,
    input wire logic [4:0] i_rx_frame_num,
    input wire logic o_rx_fs_error_count_en,
    input wire logic o_secondary_yellow_det
);
    // A shadow of the alarm word lets the line checks know the mode in force.
    logic [7:0] alarm_r;
    logic unframed_ones;
    always_ff @(posedge i_clk_sys)
    begin
        if (i_reset)
            alarm_r <= RST_TX_ALARM_CTRL;
        else if (i_cs && i_wr && i_addr == ADDR_TX_ALARM_CTRL)
            alarm_r <= i_wdata;
    end
    assign unframed_ones = (alarm_r & 8'h11) == 8'h00;
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_reset);
    sequence s_fs12;
        i_rx_sbit_strobe && i_rx_frame_num == SECONDARY_YELLOW_FRAME &&
        alarm_r[B_SECONDARY_ALARM_TRUNK];
    endsequence
    property p_rd_valid; i_cs && i_rd |=> o_rdata_valid; endproperty
    property p_rd_quiet; !(i_cs && i_rd) |=> !o_rdata_valid; endproperty
    property p_rd_hole;
        i_cs && i_rd && !(i_addr inside {[8'h11:8'h13]}) |=> o_rdata == 8'h00;
    endproperty
    property p_rd_alarm;
        i_cs && i_rd && i_addr == ADDR_TX_ALARM_CTRL
        |=> o_rdata == $past(alarm_r);
    endproperty
    property p_tx_valid; o_line_tx_valid == $past(i_bit_en); endproperty
    property p_ones;
        o_line_tx_valid && $past(unframed_ones) |-> o_line_tx_bit;
    endproperty
    property p_fs_skip; s_fs12 |-> !o_rx_fs_error_count_en; endproperty
    property p_sec_det; s_fs12 ##0 i_rx_sbit |=> o_secondary_yellow_det;
    endproperty
    a_rd_valid: assert property (p_rd_valid) else $error("read valid missing");
    a_rd_quiet: assert property (p_rd_quiet) else $error("stray read valid");
    a_rd_hole: assert property (p_rd_hole) else $error("unmapped read not zero");
    a_rd_alarm: assert property (p_rd_alarm) else $error("alarm word readback");
    a_tx_valid: assert property (p_tx_valid) else $error("line valid timing");
    a_ones: assert property (p_ones) else $error("all ones broken");
    a_fs_skip: assert property (p_fs_skip) else $error("fs counted");
    a_sec_det: assert property (p_sec_det) else $error("no flag");
endmodule
bind t1_tx_alarm_and_data_link_ctrl t1_tx_alarm_sva chk_u (.i_clk_sys,
    .i_reset, .i_cs, .i_wr, .i_rd, .i_addr, .i_wdata, .o_rdata,
    .o_rdata_valid, .i_bit_en, .o_line_tx_bit, .o_line_tx_valid,
    .i_rx_sbit_strobe, .i_rx_sbit, .i_rx_frame_num, .o_rx_fs_error_count_en,
    .o_secondary_yellow_det);

// ### tb/t1_far_end.sv
`timescale 1ns/1ps
module t1_far_end
(
    input wire logic i_clk_sys,
    output logic o_rx_strobe,
    output logic o_rx_sbit,
    output logic [4:0] o_rx_frame,
    output logic o_ext_bit
);
    logic [1:0] div_r = 2'h0;
    logic [4:0] frame_r = 5'h01;
    always @(negedge i_clk_sys)
    begin
        div_r <= div_r + 2'h1;
        if (div_r == 2'h3)
            frame_r <= (frame_r == 5'h0c) ? 5'h01 : frame_r + 5'h01;
    end
    // Off the strobe the S bit toggles, so a stale value is never trusted.
    assign o_rx_strobe = div_r == 2'h3;
    assign o_rx_frame = frame_r;
    assign o_rx_sbit = o_rx_strobe ? frame_r == 5'h0c : div_r[0];
    assign o_ext_bit = div_r[1];
endmodule

// ### tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import t1_tx_alarm_pkg::*;
    localparam logic [5:0] FT_BITS = 6'h2a, FS_BITS = 6'h0e;
    logic clk = 1'b0, rst = 1'b1, cs = 1'b0, wr = 1'b0, rd = 1'b0, bp = 1'b0;
    logic bit_en = 1'b0, crc = 1'b0, rvalid, tx_bit, tx_valid, strobe, sbit;
    logic ext;
    logic esf = 1'b0;
    logic [4:0] frame;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, r;
    logic [7:0] rd_q[$];
    logic tx_q[$];
    int miscompares = 0, cmp_count = 0;
    t1_tx_alarm_and_data_link_ctrl dut_u (.i_clk_sys(clk), .i_reset(rst),
        .i_cs(cs), .i_wr(wr), .i_rd(rd), .i_addr(addr), .i_wdata(wdata),
        .o_rdata(rdata), .o_rdata_valid(rvalid), .i_esf_mode(esf),
        .i_bit_en(bit_en), .i_backplane_data_in(bp), .o_backplane_data_take(),
        .i_crc6_bit(crc), .i_ext_link_bit(ext), .o_ext_link_take(),
        .i_hdlc_fdl_bit(1'b0), .o_hdlc_fdl_take(), .i_hdlc_chan_bit(1'b0),
        .o_hdlc_chan_take(), .o_line_tx_bit(tx_bit),
        .o_line_tx_valid(tx_valid),
        .o_line_tx_sbit(), .i_rx_sbit_strobe(strobe), .i_rx_sbit(sbit),
        .i_rx_frame_num(frame), .o_rx_fs_error_count_en(),
        .o_secondary_yellow_det(), .i_secondary_yellow_clr(1'b0),
        .o_rx_link_enable(), .o_crc_include_sbits(), .o_transparent_mode());
    t1_far_end far_u (.i_clk_sys(clk), .o_rx_strobe(strobe), .o_rx_sbit(sbit),
        .o_rx_frame(frame), .o_ext_bit(ext));
    initial forever #2.5 clk = ~clk;
    task automatic tally(input logic ok, input string m);
        cmp_count++;
        if (ok !== 1'b1) miscompares++;
        if (ok !== 1'b1) $display("BAD %0t %s", $time, m);
    endtask
    task automatic cmp_rd;
        tally(rd_q.size() > 0 && rdata === rd_q.pop_front(), "read data");
    endtask
    task automatic cmp_line;
        tally(tx_q.size() > 0 && tx_bit === tx_q.pop_front(), "line bit");
    endtask
    always @(negedge clk)
    begin
        if (rvalid === 1'b1) cmp_rd();
        if (tx_valid === 1'b1) cmp_line();
    end
    task automatic acc(input logic w, input logic [7:0] a,
        input logic [7:0] d);
        if (!w) rd_q.push_back(d);
        {cs, wr, rd, addr, wdata} = {1'b1, w, !w, a, d};
        @(negedge clk);
        {cs, wr, rd} = 3'h0;
        @(negedge clk);
    endtask
    // Slot 0 is the S bit; a channel bit 2 sits at slot 8n+2.
    // Mode 4 is ESF: odd frames carry the link, frame 2 CRC, frame 4 FPS 0.
    function automatic logic exp_bit(input int k, i, input logic [7:0] v,
        input logic c);
        if (k == 0) return 1'b1;
        if (k == 4 && i % 193 == 0) return (i / 193 == 1) ? c : i / 193 != 3;
        if (k == 1) return i % 5 == 4;
        if (k == 2) return i % 3 == 2;
        if (i % 193 != 0) return !(v[5] && i % 193 % 8 == 2);
        if (i / 193 % 2 == 0) return FT_BITS[5 - i / 386];
        if (i / 193 == 11) return v[6];
        return FS_BITS[6 - (i / 193 + 1) / 2];
    endfunction
    task automatic run(input logic [7:0] v, input int n, input int k);
        rst = 1'b1;
        esf = (k == 4);
        @(negedge clk);
        rst = 1'b0;
        acc(1'b1, ADDR_TX_ALARM_CTRL, v);
        for (int i = 0; i < n; i++)
        begin
            {bit_en, bp, crc} = {1'b1, v[4] | 1'($urandom), 1'($urandom)};
            tx_q.push_back(exp_bit(k, i, v, crc));
            @(negedge clk);
            bit_en = 1'b0;
            @(negedge clk);
        end
        @(negedge clk);
        $display("test alarm %h done", v);
    endtask
    task automatic print_verdict;
        tally(rd_q.size() + tx_q.size() == 0, "results left over");
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial
    begin
        void'($urandom(22));
        repeat (4) @(negedge clk);
        rst = 1'b0;
        acc(1'b0, ADDR_TX_ALARM_CTRL, RST_TX_ALARM_CTRL);
        acc(1'b0, ADDR_LINE_DATA_LINK_CTRL,
            RST_LINE_DATA_LINK_CTRL);
        r = 8'($urandom);
        acc(1'b1, ADDR_TX_BIT_MESSAGE, r);
        acc(1'b0, ADDR_TX_BIT_MESSAGE, r);
        acc(1'b1, 8'h14, r);
        acc(1'b0, 8'h14, 8'h00);
        $display("test registers done");
        run(8'h00, 20, 0);
        run(8'h0c, 20, 0);
        run(8'h1c, 20, 1);
        run(8'h14, 18, 2);
        run(8'h01, 386, 3);
        run(8'h30, 193, 3);
        run(8'h52, 2316, 3);
        run(8'h81, 772, 4);
        print_verdict();
    end
    initial
    begin
        #100000 tally(1'b0, "watchdog");
        print_verdict();
    end
endmodule
